//--- logic/acs_pkg.sv
package acs_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;

  // power-on window before the clocking strap is taken
  localparam int POR_TIME_US = 1000;
  localparam int POR_CYCLES = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int POR_CNT_W = 16;

  // result frame
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 23;
  localparam int BIT_CNT_W = 5;
  localparam logic EOC_DONE = 1'b0;

  // internal serial clock, half period as a least time
  localparam int SCK_HALF_NS = 1000;
  localparam int SCK_HALF_CYC =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // front-end sampling clock, internal oscillator
  localparam int SAMP_STD_HZ = 76800;
  localparam int SAMP_ALT_HZ = 69900;
  localparam int SAMP_STD_HALF = CLK_HZ / (2 * SAMP_STD_HZ);
  localparam int SAMP_ALT_HALF = CLK_HZ / (2 * SAMP_ALT_HZ);
  localparam int SAMP_CNT_W = 8;

  // external oscillator presence on the notch select pin
  localparam int OSC_IDLE_CYC = 64;
  localparam int OSC_IDLE_W = 7;

  localparam int FIFO_DEPTH = 8;

  // reset values
  localparam logic SCK_RST = 1'b1;
  localparam logic SDO_RST = 1'b1;
  localparam logic SAMP_RST = 1'b0;

  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_CONV = 5'h02,
    ST_DONE = 5'h04,
    ST_HIGH = 5'h08,
    ST_LOW = 5'h10
  } acs_state_type;

endpackage

//--- logic/acs_fifo.sv
`timescale 1ns/1ns
module acs_fifo #(
  parameter int WIDTH = acs_pkg::DATA_BITS,
  parameter int DEPTH = acs_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } acs_fifo_st_type;

  acs_fifo_st_type s_r;
  acs_fifo_st_type s_nxt;
  logic push;
  logic pop;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_ready_out = (s_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid_out = (s_r.cnt != '0);
  assign out_data_out = s_r.mem[s_r.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data_in;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    if (!rst_n_in) begin
      s_nxt.wr = '0;
      s_nxt.rd = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    s_r <= s_nxt;
  end

endmodule

//--- logic/acs_serial_out.sv
`timescale 1ns/1ns
module acs_serial_out #(
  parameter int POR_CYCLES = acs_pkg::POR_CYCLES,
  parameter bit ALT_NOTCH = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  output logic sck_pullup_out,
  output logic sdo_out,
  output logic sdo_oe_out,
  input wire logic notch_oscillator_select_in,
  output logic samp_clk_out,
  output logic ext_osc_out,
  output logic ext_sck_mode_out,
  input wire logic conv_valid_in,
  output logic conv_ready_out,
  input wire logic [acs_pkg::DATA_BITS-1:0] conv_data_in,
  output logic conv_start_out
);

  localparam int SAMP_HALF =
    ALT_NOTCH ? acs_pkg::SAMP_ALT_HALF : acs_pkg::SAMP_STD_HALF;
  localparam int HALF_C = SAMP_HALF;
  localparam int SCK_HALF_END = acs_pkg::SCK_HALF_CYC - 1;

  typedef struct packed {
    acs_pkg::acs_state_type state;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [acs_pkg::POR_CNT_W-1:0] por_cnt;
    logic ext_mode;
    logic [acs_pkg::TMR_W-1:0] tmr;
    logic [acs_pkg::BIT_CNT_W-1:0] bit_cnt;
    logic [acs_pkg::FRAME_BITS-1:0] shreg;
    logic sck;
    logic sdo;
    logic samp_clk;
    logic [acs_pkg::SAMP_CNT_W-1:0] samp_cnt;
    logic [acs_pkg::OSC_IDLE_W-1:0] osc_idle;
    logic osc_active;
    logic conv_start;
  } acs_st_type;

  acs_st_type s_r;
  acs_st_type s_nxt;
  logic fifo_valid;
  logic fifo_pop;
  logic [acs_pkg::DATA_BITS-1:0] fifo_data;
  logic osc_rise;
  logic ext_rise;
  logic ext_fall;

  function automatic logic in_frame(acs_pkg::acs_state_type st);
    in_frame = (st == acs_pkg::ST_DONE) || (st == acs_pkg::ST_HIGH) ||
               (st == acs_pkg::ST_LOW);
  endfunction

  acs_fifo #(
    .WIDTH(acs_pkg::DATA_BITS),
    .DEPTH(acs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(conv_valid_in),
    .in_ready_out(conv_ready_out),
    .in_data_in(conv_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  // edges only from the second and third stages, never the first
  assign osc_rise = s_r.osc_s2 && !s_r.osc_s3;
  assign ext_rise = s_r.sck_s2 && !s_r.sck_s3;
  assign ext_fall = !s_r.sck_s2 && s_r.sck_s3;
  assign fifo_pop = (s_r.state == acs_pkg::ST_CONV) && fifo_valid;

  assign sck_out = s_r.sck;
  assign sck_oe_out = (s_r.state != acs_pkg::ST_POR) && !s_r.ext_mode;
  assign sck_pullup_out = (s_r.state == acs_pkg::ST_POR);
  assign sdo_out = s_r.sdo;
  assign sdo_oe_out = (s_r.state != acs_pkg::ST_POR);
  assign samp_clk_out = s_r.samp_clk;
  assign ext_osc_out = s_r.osc_active;
  assign ext_sck_mode_out = s_r.ext_mode;
  assign conv_start_out = s_r.conv_start;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_s1 = sck_in;
    s_nxt.sck_s2 = s_r.sck_s1;
    s_nxt.sck_s3 = s_r.sck_s2;
    s_nxt.osc_s1 = notch_oscillator_select_in;
    s_nxt.osc_s2 = s_r.osc_s1;
    s_nxt.osc_s3 = s_r.osc_s2;
    s_nxt.conv_start = 1'b0;

    // oscillator watchdog: rising pin edges within the window mean external
    if (osc_rise) begin
      s_nxt.osc_idle = '0;
      s_nxt.osc_active = 1'b1;
    end else if (s_r.osc_idle ==
                 acs_pkg::OSC_IDLE_W'(acs_pkg::OSC_IDLE_CYC)) begin
      s_nxt.osc_active = 1'b0;
    end else begin
      s_nxt.osc_idle = s_r.osc_idle + 1'b1;
    end

    if (s_r.osc_active) begin
      s_nxt.samp_cnt = '0;
      if (osc_rise) begin
        s_nxt.samp_clk = !s_r.samp_clk;
      end
    end else if (s_r.samp_cnt == acs_pkg::SAMP_CNT_W'(SAMP_HALF - 1)) begin
      s_nxt.samp_cnt = '0;
      s_nxt.samp_clk = !s_r.samp_clk;
    end else begin
      s_nxt.samp_cnt = s_r.samp_cnt + 1'b1;
    end

    unique case (s_r.state)
      acs_pkg::ST_POR: begin
        if (s_r.por_cnt == acs_pkg::POR_CNT_W'(POR_CYCLES - 1)) begin
          s_nxt.ext_mode = !s_r.sck_s2;
          s_nxt.state = acs_pkg::ST_CONV;
        end else begin
          s_nxt.por_cnt = s_r.por_cnt + 1'b1;
        end
      end
      acs_pkg::ST_CONV: begin
        s_nxt.sck = 1'b1;
        s_nxt.sdo = 1'b1;
        if (fifo_valid) begin
          s_nxt.shreg = {acs_pkg::EOC_DONE, fifo_data};
          s_nxt.sdo = acs_pkg::EOC_DONE;
          s_nxt.sck = s_r.ext_mode;
          s_nxt.tmr = acs_pkg::TMR_W'(acs_pkg::SCK_HALF_CYC - 1);
          s_nxt.bit_cnt = '0;
          s_nxt.state = acs_pkg::ST_DONE;
        end
      end
      acs_pkg::ST_DONE: begin
        if (s_r.ext_mode) begin
          // external clock: the host paces the frame from its own edges
          if (ext_rise) begin
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
          end else if (ext_fall && s_r.bit_cnt != '0) begin
            if (s_r.bit_cnt == acs_pkg::BIT_CNT_W'(acs_pkg::FRAME_BITS)) begin
              s_nxt.sdo = 1'b1;
              s_nxt.conv_start = 1'b1;
              s_nxt.state = acs_pkg::ST_CONV;
            end else begin
              s_nxt.shreg = s_r.shreg << 1;
              s_nxt.sdo = s_r.shreg[acs_pkg::FRAME_BITS-2];
            end
          end
        end else if (s_r.tmr == '0) begin
          s_nxt.sck = 1'b1;
          s_nxt.bit_cnt = 5'h01;
          s_nxt.tmr = acs_pkg::TMR_W'(acs_pkg::SCK_HALF_CYC - 1);
          s_nxt.state = acs_pkg::ST_HIGH;
        end else begin
          s_nxt.tmr = s_r.tmr - 1'b1;
        end
      end
      acs_pkg::ST_HIGH: begin
        if (s_r.bit_cnt == acs_pkg::BIT_CNT_W'(acs_pkg::FRAME_BITS)) begin
          // one cycle after the last rise so the host still sees bit 24
          s_nxt.sdo = 1'b1;
          s_nxt.conv_start = 1'b1;
          s_nxt.state = acs_pkg::ST_CONV;
        end else if (s_r.tmr == '0) begin
          s_nxt.sck = 1'b0;
          s_nxt.shreg = s_r.shreg << 1;
          s_nxt.sdo = s_r.shreg[acs_pkg::FRAME_BITS-2];
          s_nxt.tmr = acs_pkg::TMR_W'(acs_pkg::SCK_HALF_CYC - 1);
          s_nxt.state = acs_pkg::ST_LOW;
        end else begin
          s_nxt.tmr = s_r.tmr - 1'b1;
        end
      end
      acs_pkg::ST_LOW: begin
        if (s_r.tmr == '0) begin
          s_nxt.sck = 1'b1;
          s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
          s_nxt.tmr = acs_pkg::TMR_W'(acs_pkg::SCK_HALF_CYC - 1);
          s_nxt.state = acs_pkg::ST_HIGH;
        end else begin
          s_nxt.tmr = s_r.tmr - 1'b1;
        end
      end
      default: begin
        s_nxt.state = acs_pkg::ST_POR;
      end
    endcase

    // synchronous reset; synchronisers keep sampling so the strap is valid
    if (!rst_n_in) begin
      s_nxt.state = acs_pkg::ST_POR;
      s_nxt.por_cnt = '0;
      s_nxt.ext_mode = 1'b0;
      s_nxt.tmr = '0;
      s_nxt.bit_cnt = '0;
      s_nxt.shreg = '0;
      s_nxt.sck = acs_pkg::SCK_RST;
      s_nxt.sdo = acs_pkg::SDO_RST;
      s_nxt.samp_clk = acs_pkg::SAMP_RST;
      s_nxt.samp_cnt = '0;
      s_nxt.osc_idle = '0;
      s_nxt.osc_active = 1'b0;
      s_nxt.conv_start = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    s_r <= s_nxt;
  end

  chk_sck_drive_mode: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_r.state != acs_pkg::ST_POR) |->
      (sck_oe_out == !ext_sck_mode_out) && sdo_oe_out)
    else $error("sck drive does not follow clock mode");

  chk_pullup_por: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_r.state == acs_pkg::ST_POR) |-> sck_pullup_out && !sck_oe_out)
    else $error("pull-up missing or sck driven in power-on");

  chk_mode_latch: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ((s_r.state == acs_pkg::ST_POR) &&
     (s_r.por_cnt == acs_pkg::POR_CNT_W'(POR_CYCLES - 1))) |=>
      (ext_sck_mode_out == !$past(s_r.sck_s2)) &&
      (s_r.state == acs_pkg::ST_CONV))
    else $error("clock mode not taken from sck at power-on end");

  chk_conv_high: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_r.state == acs_pkg::ST_CONV) |-> sck_out && sdo_out)
    else $error("sck or sdo low during conversion");

  chk_done_low: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (fifo_pop && !ext_sck_mode_out) |=> !sck_out && !sdo_out
      && (s_r.shreg[acs_pkg::DATA_BITS-1:0] == $past(fifo_data)))
    else $error("completion not shown as sck and sdo low");

  chk_frame_len: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ((s_r.state == acs_pkg::ST_CONV) && in_frame($past(s_r.state)) &&
     !ext_sck_mode_out) |->
      ($past(s_r.bit_cnt) == acs_pkg::BIT_CNT_W'(acs_pkg::FRAME_BITS)))
    else $error("frame did not end after the 24th rise");

  chk_sdo_on_fall: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!ext_sck_mode_out && $changed(sdo_out) &&
     ((s_r.state == acs_pkg::ST_HIGH) || (s_r.state == acs_pkg::ST_LOW)))
      |-> $fell(sck_out))
    else $error("sdo moved away from a falling sck edge");

  chk_end_raise: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!ext_sck_mode_out && (s_r.state == acs_pkg::ST_HIGH) &&
     (s_r.bit_cnt == acs_pkg::BIT_CNT_W'(acs_pkg::FRAME_BITS))) |=>
      sdo_out && sck_out && conv_start_out ##1 !conv_start_out)
    else $error("frame end did not raise sdo and restart");

  chk_samp_int: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($rose(samp_clk_out) && !s_r.osc_active) |->
      ##[HALF_C:HALF_C] ($fell(samp_clk_out) || s_r.osc_active ||
                         $past(s_r.osc_active, 2)))
    else $error("internal sampling half period wrong");

  chk_samp_ext: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_r.osc_active && osc_rise) |=>
      (samp_clk_out != $past(samp_clk_out)))
    else $error("sampling clock not toggled by external oscillator");

  chk_eoc_first: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    fifo_pop |=> (s_r.shreg[acs_pkg::FRAME_BITS-1] == acs_pkg::EOC_DONE)
      && (sdo_out == acs_pkg::EOC_DONE))
    else $error("frame does not open with the done bit");

  chk_sck_low_len: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($fell(sck_out) && !ext_sck_mode_out &&
     (s_r.state == acs_pkg::ST_LOW)) |->
      ##[SCK_HALF_END:SCK_HALF_END] !sck_out ##1 sck_out)
    else $error("internal sck low half has the wrong length");

  chk_sck_high_len: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ($rose(sck_out) && !ext_sck_mode_out &&
     (s_r.state == acs_pkg::ST_HIGH) &&
     (s_r.bit_cnt != acs_pkg::BIT_CNT_W'(acs_pkg::FRAME_BITS))) |->
      ##[SCK_HALF_END:SCK_HALF_END] sck_out ##1 !sck_out)
    else $error("internal sck high half has the wrong length");

  chk_start_pulse: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    conv_start_out |-> (s_r.state == acs_pkg::ST_CONV) && sdo_out &&
      !$past(conv_start_out))
    else $error("conversion start not one pulse on entering convert");

  cov_frame_done: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_r.state == acs_pkg::ST_HIGH) ##1 (s_r.state == acs_pkg::ST_CONV));

  cov_ext_mode: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(ext_sck_mode_out));

  cov_ext_osc: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(ext_osc_out));

  cov_fifo_full: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    conv_valid_in && !conv_ready_out);

endmodule

//--- tb/acs_host_model.sv
`timescale 1ns/1ns
module acs_host_model (
  input wire logic sck_pin_in,
  input wire logic sdo_pin_in,
  input wire logic ext_mode_in,
  input wire logic listen_in,
  output logic sck_drv_out,
  output logic sck_drv_en_out,
  output logic [23:0] word_out,
  output int count_out
);
  logic [23:0] shift;
  // external mode: host holds sck low through power-on and clocks frames
  assign sck_drv_en_out = ext_mode_in;
  initial begin
    sck_drv_out = 1'b0;
    word_out = 24'h000000;
    count_out = 0;
  end
  // done flag falling starts a frame; ignored while told not to listen
  always begin
    do @(negedge sdo_pin_in); while (!listen_in);
    shift = 24'h000000;
    // offset keeps host edges off the block's clock edges
    if (ext_mode_in) #10;
    for (int i = 0; i < 24; i++) begin
      if (ext_mode_in) begin
        // 250 ns low gives the block's edge sync time to shift sdo
        #250 sck_drv_out = 1'b1;
      end else begin
        @(posedge sck_pin_in);
      end
      shift = {shift[22:0], sdo_pin_in};
      if (ext_mode_in) #150 sck_drv_out = 1'b0;
    end
    word_out = shift;
    count_out = count_out + 1;
  end
endmodule

//--- tb/adc_continuous_serial_output_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) check_eq(32'(g), 32'(e))
module adc_continuous_serial_output_tb;
  localparam int STD_HZ = 76800;
  localparam int ALT_HZ = 69900;
  localparam int OSC_PER = 12;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic notch = 1'b0;
  logic conv_valid_in = 1'b0;
  logic [22:0] conv_data_in = 23'h000000;
  logic sck_out, sck_oe_out, sck_pullup_out, sdo_out, sdo_oe_out;
  logic samp_clk_out, ext_osc_out, ext_sck_mode_out;
  logic samp_alt;
  logic conv_ready_out, conv_start_out;
  logic sck_pin, sdo_pin, hst_drv, hst_en;
  logic sck_hold = 1'b0;
  logic sdo_hold = 1'b0;
  logic ext_mode = 1'b0;
  logic listen = 1'b1;
  logic osc_on = 1'b0;
  logic [23:0] host_word;
  logic [22:0] exp_q[$];
  int host_count;
  int osc_div = 0;
  int cyc = 0;
  int fail_count = 0;
  int compares = 0;

  acs_serial_out #(.POR_CYCLES(20), .ALT_NOTCH(1'b0)) dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sck_in(sck_pin),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out),
    .sck_pullup_out(sck_pullup_out), .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out), .notch_oscillator_select_in(notch),
    .samp_clk_out(samp_clk_out), .ext_osc_out(ext_osc_out),
    .ext_sck_mode_out(ext_sck_mode_out), .conv_valid_in(conv_valid_in),
    .conv_ready_out(conv_ready_out), .conv_data_in(conv_data_in),
    .conv_start_out(conv_start_out));

  acs_host_model host (.sck_pin_in(sck_pin), .sdo_pin_in(sdo_pin),
    .ext_mode_in(ext_mode), .listen_in(listen), .sck_drv_out(hst_drv),
    .sck_drv_en_out(hst_en), .word_out(host_word),
    .count_out(host_count));

  // alternate notch variant, only its sampling clock is watched
  acs_serial_out #(.POR_CYCLES(20), .ALT_NOTCH(1'b1)) dut_alt (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sck_in(1'b1),
    .sck_out(), .sck_oe_out(), .sck_pullup_out(), .sdo_out(),
    .sdo_oe_out(), .notch_oscillator_select_in(1'b0),
    .samp_clk_out(samp_alt), .ext_osc_out(), .ext_sck_mode_out(),
    .conv_valid_in(1'b0), .conv_ready_out(),
    .conv_data_in(23'h000000), .conv_start_out());

  // released pins show the host drive or the pull-up on sck, otherwise the inverse of their last driven level
  assign sck_pin = (sck_oe_out === 1'b1) ? sck_out : hst_en ? hst_drv :
    (sck_pullup_out === 1'b1) ? 1'b1 : ~sck_hold;
  assign sdo_pin = (sdo_oe_out === 1'b1) ? sdo_out : ~sdo_hold;

  always #25 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    if (sck_oe_out === 1'b1) sck_hold <= sck_out;
    if (sdo_oe_out === 1'b1) sdo_hold <= sdo_out;
    if (osc_on) begin
      osc_div <= (osc_div == OSC_PER / 2 - 1) ? 0 : osc_div + 1;
      if (osc_div == OSC_PER / 2 - 1) notch <= ~notch;
    end
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  function automatic logic [23:0] exp_frame(input logic [22:0] d);
    // done bit low leads, then data msb first
    return {1'b0, d};
  endfunction

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH time=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic reset_dut();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
  endtask

  // valid stays up between pushes; caller lowers it afterwards
  task automatic push(input logic [22:0] w);
    int k;
    k = 0;
    conv_valid_in <= 1'b1;
    conv_data_in <= w;
    @(posedge ref_clk_in);
    while (conv_ready_out !== 1'b1 && k < 3000) begin
      @(posedge ref_clk_in);
      k++;
    end
    `CHK(conv_ready_out, 1'b1);
    exp_q.push_back(w);
  endtask

  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (host_count < n && k < 15000) begin
      @(posedge ref_clk_in);
      k++;
    end
    `CHK(host_count, n);
  endtask

  task automatic wait_lvl(input logic alt, input logic v, inout int n);
    while ((alt ? samp_alt : samp_clk_out) !== v && n < 600) begin
      @(posedge ref_clk_in);
      n++;
    end
  endtask

  task automatic samp_period(input logic alt, output int n);
    n = 0;
    wait_lvl(alt, 1'b0, n);
    wait_lvl(alt, 1'b1, n);
    n = 0;
    wait_lvl(alt, 1'b0, n);
    wait_lvl(alt, 1'b1, n);
  endtask

  always @(host_count) begin
    if (exp_q.size() == 0) begin
      `CHK(host_word, 24'hxxxxxx);
    end else begin
      `CHK(host_word, exp_frame(exp_q.pop_front()));
    end
    if (!ext_mode) begin
      @(posedge ref_clk_in);
      #1;
      `CHK({conv_start_out, sdo_out, sck_out}, 3'b111);
    end
  end

  initial begin
    int n;
    void'($urandom(66025));
    notch = 1'($urandom % 2);
    reset_dut();
    // fill during power-on: nothing drains yet, so the ninth must wait
    for (int i = 0; i < 8; i++)
      push(i == 0 ? 23'h7FFFFF : (i == 1 ? 23'h000000 : 23'($urandom)));
    #1;
    `CHK(conv_ready_out, 1'b0);
    `CHK({sck_pullup_out, sck_oe_out}, 2'b10);
    push(23'($urandom));
    conv_valid_in <= 1'b0;
    wait_words(9);
    `CHK(ext_sck_mode_out, 1'b0);
    `CHK({sck_oe_out, sdo_oe_out}, 2'b11);
    repeat (5) @(posedge ref_clk_in);
    `CHK({sck_out, sdo_out}, 2'b11);
    `CHK(conv_ready_out, 1'b1);
    samp_period(1'b0, n);
    `CHK(n, 2 * (acs_pkg::CLK_HZ / (2 * STD_HZ)));
    samp_period(1'b1, n);
    `CHK(n, 2 * (acs_pkg::CLK_HZ / (2 * ALT_HZ)));
    osc_on <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
    `CHK(ext_osc_out, 1'b1);
    samp_period(1'b0, n);
    `CHK(n, 2 * OSC_PER);
    osc_on <= 1'b0;
    repeat (100) @(posedge ref_clk_in);
    `CHK(ext_osc_out, 1'b0);
    samp_period(1'b0, n);
    `CHK(n, 2 * (acs_pkg::CLK_HZ / (2 * STD_HZ)));
    listen = 1'b0;
    ext_mode = 1'b1;
    reset_dut();
    repeat (10) @(posedge ref_clk_in);
    `CHK(ext_sck_mode_out, 1'b0);
    repeat (15) @(posedge ref_clk_in);
    `CHK({ext_sck_mode_out, sck_oe_out}, 2'b10);
    listen = 1'b1;
    push(23'h2AAAAA);
    push(23'($urandom));
    conv_valid_in <= 1'b0;
    wait_words(11);
    repeat (20) @(posedge ref_clk_in);
    `CHK(sdo_out, 1'b1);
    `CHK(exp_q.size(), 0);
    end_of_test();
  end
endmodule
